// ===== core/ftc_cal_engine.sv
// RC calibration engine with measurement, count correction and self test.
`timescale 1ns/1ns
`default_nettype none
module ftc_cal_engine
  import ftc_pkg::*;
#(
  parameter int BIST_CYCLES = FTC_BIST_CYCLES
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        start_i,
  input  wire logic        self_test_i,
  input  wire logic        cal_en_i,
  input  wire logic [14:0] period_i,
  input  wire logic [8:0]  adj_i,
  input  wire logic        cmp_i,
  output var  logic        busy_o,
  output var  logic [3:0]  code_o,
  output var  logic [23:0] count_o,
  output var  logic [15:0] sig_o
);
  ftc_cal_state_t st_ff;
  logic [23:0]    acc_ff;
  logic [17:0]    tick_ff;
  logic [3:0]     code_ff;
  logic [15:0]    sig_ff;
  wire  [23:0]    nxt_acc = acc_ff + {9'h000, period_i};
  wire  [24:0]    adj_ps  = {{6{adj_i[8]}}, adj_i, 10'h000};
  wire  [24:0]    corr    = {1'b0, acc_ff} + adj_ps;
  wire  [11:0]    step    = corr[23:FTC_CAL_SHIFT];
  wire  [3:0]     decoded = corr[24] ? 4'h0 :
                            (step > {8'h00, FTC_FINE_MAX}) ? FTC_FINE_MAX : step[3:0];
  wire            fb      = sig_ff[15] ^ sig_ff[13] ^ sig_ff[12] ^ sig_ff[10];
  wire  [15:0]    nxt_sig = {sig_ff[14:0], fb} ^ {1'b0, period_i};
  wire  [17:0]    tick_ld = 18'(BIST_CYCLES - 1);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff   <= FTC_IDLE;
      acc_ff  <= 24'h00_0000;
      tick_ff <= 18'h0_0000;
      code_ff <= FTC_FINE_RST;
      sig_ff  <= 16'h0000;
    end else begin
      case (st_ff)
        FTC_IDLE: begin
          if (start_i && self_test_i) begin
            st_ff   <= FTC_BIST;
            tick_ff <= tick_ld;
            sig_ff  <= FTC_SIG_SEED;
            acc_ff  <= 24'h00_0000;
          end else if (start_i && cal_en_i) begin
            st_ff  <= FTC_MEAS;
            acc_ff <= 24'h00_0000;
          end
        end
        FTC_MEAS: begin
          if (cmp_i) begin
            code_ff <= decoded;
            st_ff   <= FTC_IDLE;
          end else begin
            acc_ff <= nxt_acc;
          end
        end
        FTC_BIST: begin
          sig_ff  <= nxt_sig;
          acc_ff  <= nxt_acc;
          tick_ff <= tick_ff - 18'h0_0001;
          if (tick_ff == 18'h0_0000) st_ff <= FTC_IDLE;
        end
        default: st_ff <= FTC_IDLE;
      endcase
    end
  end

  assign busy_o  = (st_ff != FTC_IDLE);
  assign code_o  = code_ff;
  assign count_o = acc_ff;
  assign sig_o   = sig_ff;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_meas_accumulate: assert property (
    (st_ff == FTC_MEAS) && !cmp_i |=> acc_ff == $past(acc_ff) + {9'h000, $past(period_i)})
    else $error("Measurement count did not advance by the period.");
  a_code_clamped: assert property (
    (st_ff == FTC_MEAS) && cmp_i |=> (code_ff <= FTC_FINE_MAX) && (st_ff == FTC_IDLE))
    else $error("Decoded tuning code out of range.");
endmodule : ftc_cal_engine
`default_nettype wire

// ===== core/ftc_regs.sv
// Serial register bank and setting selection for the dual filter tuning control.
`timescale 1ns/1ns
`default_nettype none
// Contract
// - Nonvolatile values replace registers unless ignore bit set or memory unprogrammed.
// - Enable bit one turns the calibration circuit on; resets to zero.
// - In-phase and quadrature path enables each power their path; both reset one.
// - Override bit applies the stored fine code instead of the engine result.
// - Doubler bit: clear uses 40-80 MHz clock directly, set doubles 20-40 MHz.
// - Amplifier bias field spans min 00 to max 11; resets to 01.
// - Driver bias field spans min 00 to max 11; resets to 10.
// - Gain bit selects 0 dB when clear, 10 dB when set; resets clear.
// - Bypass bit routes signals around the filter when set; resets clear.
// - Coarse code 0000 to 1000 selects 3.5 to 50 MHz; resets 0000.
// - Fine override code spans 0000 to 1011; used only under override.
// - A write to the strobe register starts a calibration cycle when the enable bit is set and the engine is idle; self test mode takes precedence.
// - The strobe starts the engine self test when self test mode is selected.
// - Host programs the reference period in picoseconds; engine uses it; resets zero.
// - Signed correction in 1.024 ns units is added before decoding the count.
module ftc_regs
  import ftc_pkg::*;
#(
  parameter int BIST_CYCLES = FTC_BIST_CYCLES
) (
  input  wire logic        CLK_I,
  input  wire logic        SYS_RST_I,
  input  wire logic        SPI_SEN_N_I,
  input  wire logic        SPI_SCK_I,
  input  wire logic        SPI_SDI_I,
  output var  logic        SPI_SDO_O,
  output var  logic        SPI_SDO_OE_N_O,
  input  wire logic        RC_CMP_I,
  input  wire logic        SELF_TEST_MODE_I,
  input  wire ftc_nv_t     NV_I,
  output var  ftc_analog_t SET_O,
  output var  logic        NV_IN_USE_O,
  output var  logic        CAL_BUSY_O,
  output var  logic [23:0] CAL_COUNT_O,
  output var  logic [15:0] SELF_TEST_SIG_O
);
  // Pin synchronisers; the third sck and sen stages only serve edge detection.
  logic [1:0]  sen_sync_ff;
  logic [1:0]  sck_sync_ff;
  logic [1:0]  sdi_sync_ff;
  logic [1:0]  cmp_sync_ff;
  logic        sen_dly_ff;
  logic        sck_dly_ff;

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      sen_sync_ff <= 2'h3;
      sck_sync_ff <= 2'h0;
      sdi_sync_ff <= 2'h0;
      cmp_sync_ff <= 2'h0;
      sen_dly_ff  <= 1'b1;
      sck_dly_ff  <= 1'b0;
    end else begin
      sen_sync_ff <= {sen_sync_ff[0], SPI_SEN_N_I};
      sck_sync_ff <= {sck_sync_ff[0], SPI_SCK_I};
      sdi_sync_ff <= {sdi_sync_ff[0], SPI_SDI_I};
      cmp_sync_ff <= {cmp_sync_ff[0], RC_CMP_I};
      sen_dly_ff  <= sen_sync_ff[1];
      sck_dly_ff  <= sck_sync_ff[1];
    end
  end

  wire sen_act  = !sen_sync_ff[1];
  wire sen_fall = !sen_sync_ff[1] && sen_dly_ff;
  wire sen_rise = sen_sync_ff[1] && !sen_dly_ff;
  wire sck_rise = sck_sync_ff[1] && !sck_dly_ff;

  logic [31:0] rx_word;
  logic [5:0]  rx_cnt;

  ftc_spi_rx u_rx (
    .clk_i      (CLK_I),
    .rst_i      (SYS_RST_I),
    .sen_act_i  (sen_act),
    .sck_rise_i (sck_rise),
    .sdi_i      (sdi_sync_ff[1]),
    .word_o     (rx_word),
    .cnt_o      (rx_cnt)
  );

  // Frame decode: data in the top 24 bits, then register and chip address.
  wire [23:0] wr_data  = rx_word[31:8];
  wire [4:0]  wr_adr   = rx_word[7:3];
  wire [2:0]  wr_chip  = rx_word[2:0];
  wire        frame_ok = sen_rise && (rx_cnt == FTC_FRAME_LEN);
  wire        chip_hit = frame_ok && (wr_chip == FTC_CHIP_ADR);
  wire        chip_mis = frame_ok && (wr_chip != FTC_CHIP_ADR);
  wire        wr_rdsel = chip_hit && (wr_adr == FTC_ADR_RDSEL);
  wire        wr_en    = chip_hit && (wr_adr == FTC_ADR_ENABLES);
  wire        wr_as    = chip_hit && (wr_adr == FTC_ADR_ANALOG);
  wire        wr_fine  = chip_hit && (wr_adr == FTC_ADR_FINE);
  wire        wr_strb  = chip_hit && (wr_adr == FTC_ADR_STROBE);
  wire        wr_per   = chip_hit && (wr_adr == FTC_ADR_PERIOD);
  wire        wr_corr  = chip_hit && (wr_adr == FTC_ADR_CORR);

  // Control registers keep only their defined fields.
  logic [4:0]  rdsel_ff;
  logic [5:0]  en_ff;
  logic [9:0]  as_ff;
  logic [3:0]  fine_ff;
  logic [14:0] per_ff;
  logic [8:0]  corr_ff;

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      rdsel_ff <= FTC_RDSEL_RST;
      en_ff    <= FTC_EN_RST;
      as_ff    <= FTC_AS_RST;
      fine_ff  <= FTC_FINE_RST;
      per_ff   <= FTC_PERIOD_RST;
      corr_ff  <= FTC_CORR_RST;
    end else begin
      if (wr_rdsel) rdsel_ff <= wr_data[4:0];
      if (wr_en)    en_ff    <= wr_data[5:0];
      if (wr_as)    as_ff    <= wr_data[9:0];
      if (wr_fine)  fine_ff  <= wr_data[3:0];
      if (wr_per)   per_ff   <= wr_data[14:0];
      if (wr_corr)  corr_ff  <= wr_data[8:0];
    end
  end

  // The doubler halves the period seen per counted edge.
  wire [14:0] per_eff = en_ff[FTC_EN_DBL] ? {1'b0, per_ff[14:1]} : per_ff;

  logic        eng_busy;
  logic [3:0]  eng_code;
  logic [23:0] eng_count;
  logic [15:0] eng_sig;

  ftc_cal_engine #(
    .BIST_CYCLES (BIST_CYCLES)
  ) u_eng (
    .clk_i       (CLK_I),
    .rst_i       (SYS_RST_I),
    .start_i     (wr_strb),
    .self_test_i (SELF_TEST_MODE_I),
    .cal_en_i    (en_ff[FTC_EN_CAL]),
    .period_i    (per_eff),
    .adj_i       (corr_ff),
    .cmp_i       (cmp_sync_ff[1]),
    .busy_o      (eng_busy),
    .code_o      (eng_code),
    .count_o     (eng_count),
    .sig_o       (eng_sig)
  );

  // Setting selection between the nonvolatile copy and the registers.
  wire use_nv = !en_ff[FTC_EN_NVIGN] && NV_I.programmed;
  wire [3:0] fine_sel = use_nv ? NV_I.fine_code :
                        en_ff[FTC_EN_OVR] ? fine_ff : eng_code;

  ftc_analog_t nxt_set;
  assign nxt_set.path_i_en        = en_ff[FTC_EN_PATH_I];
  assign nxt_set.path_q_en        = en_ff[FTC_EN_PATH_Q];
  assign nxt_set.cal_en           = en_ff[FTC_EN_CAL];
  assign nxt_set.doubler_en       = en_ff[FTC_EN_DBL];
  assign nxt_set.opamp_bias       = use_nv ? NV_I.opamp_bias : as_ff[FTC_AS_OPB +: 2];
  assign nxt_set.drvr_bias        = use_nv ? NV_I.drvr_bias : as_ff[FTC_AS_DRB +: 2];
  assign nxt_set.high_gain_select = use_nv ? NV_I.high_gain_select : as_ff[FTC_AS_GAIN];
  assign nxt_set.bypass           = use_nv ? NV_I.bypass : as_ff[FTC_AS_BYP];
  assign nxt_set.coarse_code      = use_nv ? NV_I.coarse_code : as_ff[FTC_AS_CRS +: 4];
  assign nxt_set.fine_code        = fine_sel;

  // Read-back word; the strobe and spare slots hold nothing and read zero.
  logic [23:0] rd_word;
  always_comb begin
    rd_word = 24'h00_0000;
    case (rdsel_ff)
      FTC_ADR_RDSEL:   rd_word = {19'h0_0000, rdsel_ff};
      FTC_ADR_ENABLES: rd_word = {18'h0_0000, en_ff};
      FTC_ADR_ANALOG:  rd_word = {14'h0000, as_ff};
      FTC_ADR_FINE:    rd_word = {20'h0_0000, fine_ff};
      FTC_ADR_PERIOD:  rd_word = {9'h000, per_ff};
      FTC_ADR_CORR:    rd_word = {15'h0000, corr_ff};
      default:         rd_word = 24'h00_0000;
    endcase
  end

  // Output shifter: the frame after the address write returns data MSB first.
  logic [31:0] tx_ff;
  logic        sdo_ff;
  logic        sdo_oe_n_ff;
  wire  [31:0] tx_load = {rd_word, rdsel_ff, FTC_CHIP_ADR};

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      tx_ff       <= 32'h0000_0000;
      sdo_ff      <= 1'b0;
      sdo_oe_n_ff <= 1'b1;
    end else begin
      if (sen_fall) tx_ff <= tx_load;
      else if (sen_act && sck_rise) tx_ff <= {tx_ff[30:0], 1'b0};
      if (sen_act && sck_rise) sdo_ff <= tx_ff[31];
      // Only a frame to another chip address releases the shared line.
      if (chip_hit) sdo_oe_n_ff <= 1'b0;
      else if (chip_mis) sdo_oe_n_ff <= 1'b1;
    end
  end

  // Registered outputs.
  ftc_analog_t set_ff;
  logic        nv_use_ff;
  logic        busy_ff;
  logic [23:0] count_ff;
  logic [15:0] sig_ff;

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      set_ff    <= '0;
      nv_use_ff <= 1'b0;
      busy_ff   <= 1'b0;
      count_ff  <= 24'h00_0000;
      sig_ff    <= 16'h0000;
    end else begin
      set_ff    <= nxt_set;
      nv_use_ff <= use_nv;
      busy_ff   <= eng_busy;
      count_ff  <= eng_count;
      sig_ff    <= eng_sig;
    end
  end

  assign SET_O           = set_ff;
  assign NV_IN_USE_O     = nv_use_ff;
  assign CAL_BUSY_O      = busy_ff;
  assign CAL_COUNT_O     = count_ff;
  assign SELF_TEST_SIG_O = sig_ff;
  assign SPI_SDO_O       = sdo_ff;
  assign SPI_SDO_OE_N_O  = sdo_oe_n_ff;

  default clocking @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);

  a_nv_priority: assert property (
    use_nv |=> (SET_O.fine_code == $past(NV_I.fine_code))
               && (SET_O.coarse_code == $past(NV_I.coarse_code)))
    else $error("Nonvolatile settings not applied.");
  a_cal_enable_gate: assert property (
    wr_strb && !eng_busy && !en_ff[FTC_EN_CAL] && !SELF_TEST_MODE_I |=> !eng_busy)
    else $error("Calibration started while disabled.");
  a_reset_defaults: assert property (
    $past(SYS_RST_I) |-> (en_ff == FTC_EN_RST) && (as_ff == FTC_AS_RST) ##1 SET_O.path_i_en)
    else $error("Register reset values wrong.");
  a_override_fine: assert property (
    !use_nv && en_ff[FTC_EN_OVR] |=> SET_O.fine_code == $past(fine_ff))
    else $error("Fine override code not applied.");
  a_doubler_period: assert property (
    eng_busy && !cmp_sync_ff[1] && en_ff[FTC_EN_DBL]
      |=> eng_count == $past(eng_count) + {10'h000, $past(per_ff[14:1])})
    else $error("Doubler does not halve the period.");
  a_analog_select: assert property (
    !use_nv |=> (SET_O.high_gain_select == $past(as_ff[FTC_AS_GAIN]))
                && (SET_O.bypass == $past(as_ff[FTC_AS_BYP]))
                && (SET_O.coarse_code == $past(as_ff[FTC_AS_CRS +: 4])))
    else $error("Analog settings not taken from registers.");
  a_strobe_launch: assert property (
    wr_strb && !eng_busy && en_ff[FTC_EN_CAL] |=> eng_busy ##1 CAL_BUSY_O)
    else $error("Strobe write did not start calibration.");
  a_self_test_launch: assert property (
    wr_strb && !eng_busy && SELF_TEST_MODE_I |=> eng_busy [*8])
    else $error("Strobe write did not start self test.");
  a_period_store: assert property (
    wr_per |=> per_ff == $past(wr_data[14:0]))
    else $error("Reference period not stored.");
  a_reserved_zero: assert property (
    (rdsel_ff == FTC_ADR_STROBE) || (rdsel_ff == FTC_ADR_SPARE) |-> rd_word == 24'h00_0000)
    else $error("Empty register reads nonzero.");
  a_engine_fine: assert property (
    !use_nv && !en_ff[FTC_EN_OVR] |=> SET_O.fine_code == $past(eng_code))
    else $error("Calibrated fine code not applied.");

  // Each written field lands whole, and every output but the two serial line outputs and the self test signature mirrors its source one cycle later.
  a_enable_store: assert property (
    wr_en |=> en_ff == $past(wr_data[5:0]))
    else $error("Enable register not stored.");
  a_analog_store: assert property (
    wr_as |=> as_ff == $past(wr_data[9:0]))
    else $error("Analog settings not stored.");
  a_fine_store: assert property (
    wr_fine |=> fine_ff == $past(wr_data[3:0]))
    else $error("Fine override code not stored.");
  a_corr_store: assert property (
    wr_corr |=> corr_ff == $past(wr_data[8:0]))
    else $error("Count correction not stored.");
  a_reg_reset: assert property (
    $past(SYS_RST_I) |-> (per_ff == FTC_PERIOD_RST) && (corr_ff == FTC_CORR_RST)
                         && (fine_ff == FTC_FINE_RST))
    else $error("Tuning registers not cleared by reset.");
  a_path_enables: assert property (
    !SYS_RST_I |=> (SET_O.path_i_en == $past(en_ff[FTC_EN_PATH_I]))
                   && (SET_O.path_q_en == $past(en_ff[FTC_EN_PATH_Q])))
    else $error("Path enables not applied.");
  a_cal_enable_out: assert property (
    !SYS_RST_I |=> SET_O.cal_en == $past(en_ff[FTC_EN_CAL]))
    else $error("Calibration enable not applied.");
  a_doubler_out: assert property (
    !SYS_RST_I |=> SET_O.doubler_en == $past(en_ff[FTC_EN_DBL]))
    else $error("Doubler select not applied.");
  a_bias_select: assert property (
    !use_nv |=> (SET_O.opamp_bias == $past(as_ff[FTC_AS_OPB +: 2]))
                && (SET_O.drvr_bias == $past(as_ff[FTC_AS_DRB +: 2])))
    else $error("Bias settings not taken from registers.");
  a_nv_analog: assert property (
    use_nv |=> (SET_O.opamp_bias == $past(NV_I.opamp_bias))
               && (SET_O.drvr_bias == $past(NV_I.drvr_bias))
               && (SET_O.high_gain_select == $past(NV_I.high_gain_select))
               && (SET_O.bypass == $past(NV_I.bypass)))
    else $error("Nonvolatile analog settings not applied.");
  a_nv_flag_out: assert property (
    !SYS_RST_I |=> NV_IN_USE_O == $past(!en_ff[FTC_EN_NVIGN] && NV_I.programmed))
    else $error("Nonvolatile flag wrong.");
  a_short_frame: assert property (
    sen_rise && (rx_cnt != FTC_FRAME_LEN)
      |=> $stable(en_ff) && $stable(as_ff) && $stable(fine_ff) && $stable(per_ff))
    else $error("Incomplete frame changed a register.");
  a_chip_drive: assert property (
    chip_hit |=> !SPI_SDO_OE_N_O)
    else $error("Addressed frame did not take the output line.");
  a_chip_release: assert property (
    chip_mis |=> SPI_SDO_OE_N_O)
    else $error("Frame for another chip did not release the output line.");
  a_busy_mirror: assert property (
    !SYS_RST_I |=> CAL_BUSY_O == $past(eng_busy))
    else $error("Busy output does not follow the engine.");
  a_count_mirror: assert property (
    !SYS_RST_I |=> CAL_COUNT_O == $past(eng_count))
    else $error("Count output does not follow the engine.");

  c_nv_applied: cover property (use_nv ##1 NV_IN_USE_O);
  c_cal_run: cover property (wr_strb && en_ff[FTC_EN_CAL] ##[1:200] !eng_busy);
  c_self_test: cover property (wr_strb && SELF_TEST_MODE_I ##1 eng_busy);
  c_read_drive: cover property (wr_rdsel ##[1:300] sen_fall);
  c_release: cover property (chip_mis && !SPI_SDO_OE_N_O);
endmodule : ftc_regs
`default_nettype wire

// ===== core/ftc_spi_rx.sv
// Serial frame receiver that gathers the 32 bits shifted in while enabled.
`timescale 1ns/1ns
`default_nettype none
module ftc_spi_rx
  import ftc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        sen_act_i,
  input  wire logic        sck_rise_i,
  input  wire logic        sdi_i,
  output var  logic [31:0] word_o,
  output var  logic [5:0]  cnt_o
);
  logic [31:0] sr_ff;
  logic [5:0]  cnt_ff;
  wire         take = sen_act_i && sck_rise_i;
  wire  [5:0]  nxt_cnt = (cnt_ff == FTC_FRAME_LEN) ? cnt_ff : cnt_ff + 6'h01;

  // The count saturates so an over-long frame is still seen as complete.
  always_ff @(posedge clk_i) begin
    if (rst_i || !sen_act_i) cnt_ff <= 6'h00;
    else if (take) cnt_ff <= nxt_cnt;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) sr_ff <= 32'h0000_0000;
    else if (take) sr_ff <= {sr_ff[30:0], sdi_i};
  end

  assign word_o = sr_ff;
  assign cnt_o  = cnt_ff;
endmodule : ftc_spi_rx
`default_nettype wire

// ===== inc/ftc_pkg.sv
// Constants and carrier types for the filter tuning control register bank.
package ftc_pkg;
  localparam logic [5:0]  FTC_FRAME_LEN    = 6'h20;
  localparam logic [2:0]  FTC_CHIP_ADR     = 3'h5;
  localparam logic [4:0]  FTC_ADR_RDSEL    = 5'h00;
  localparam logic [4:0]  FTC_ADR_ENABLES  = 5'h01;
  localparam logic [4:0]  FTC_ADR_ANALOG   = 5'h02;
  localparam logic [4:0]  FTC_ADR_FINE     = 5'h03;
  localparam logic [4:0]  FTC_ADR_STROBE   = 5'h04;
  localparam logic [4:0]  FTC_ADR_PERIOD   = 5'h05;
  localparam logic [4:0]  FTC_ADR_CORR     = 5'h06;
  localparam logic [4:0]  FTC_ADR_SPARE    = 5'h07;
  localparam int          FTC_EN_NVIGN     = 0;
  localparam int          FTC_EN_CAL       = 1;
  localparam int          FTC_EN_PATH_I    = 2;
  localparam int          FTC_EN_PATH_Q    = 3;
  localparam int          FTC_EN_OVR       = 4;
  localparam int          FTC_EN_DBL       = 5;
  localparam int          FTC_AS_OPB       = 0;
  localparam int          FTC_AS_DRB       = 2;
  localparam int          FTC_AS_GAIN      = 4;
  localparam int          FTC_AS_BYP       = 5;
  localparam int          FTC_AS_CRS       = 6;
  localparam logic [5:0]  FTC_EN_RST       = 6'h0C;
  localparam logic [9:0]  FTC_AS_RST       = 10'h009;
  localparam logic [3:0]  FTC_FINE_RST     = 4'h0;
  localparam logic [14:0] FTC_PERIOD_RST   = 15'h0000;
  localparam logic [8:0]  FTC_CORR_RST     = 9'h000;
  localparam logic [4:0]  FTC_RDSEL_RST    = 5'h00;
  localparam logic [3:0]  FTC_FINE_MAX     = 4'hB;
  localparam logic [15:0] FTC_SIG_SEED     = 16'hFFFF;
  localparam int          FTC_ADJ_SHIFT    = 10;
  localparam int          FTC_CAL_SHIFT    = 12;
  localparam int          FTC_BIST_CYCLES  = 262144;

  typedef struct packed {
    logic       path_i_en;
    logic       path_q_en;
    logic       cal_en;
    logic       doubler_en;
    logic [1:0] opamp_bias;
    logic [1:0] drvr_bias;
    logic       high_gain_select;
    logic       bypass;
    logic [3:0] coarse_code;
    logic [3:0] fine_code;
  } ftc_analog_t;

  typedef struct packed {
    logic       programmed;
    logic [3:0] fine_code;
    logic [3:0] coarse_code;
    logic       high_gain_select;
    logic       bypass;
    logic [1:0] opamp_bias;
    logic [1:0] drvr_bias;
  } ftc_nv_t;

  typedef enum logic [1:0] {FTC_IDLE, FTC_MEAS, FTC_BIST} ftc_cal_state_t;
endpackage : ftc_pkg

// ===== sim/ftc_spi_host.sv
// Serial host model that shifts frames into the register bank and samples its output.
`timescale 1ns/1ns
`default_nettype none
module ftc_spi_host #(
  parameter int HALF = 6
) (
  input  wire logic clk_i,
  input  wire logic sdo_i,
  output var  logic sen_n_o,
  output var  logic sck_o,
  output var  logic sdi_o
);
  initial begin
    sen_n_o = 1'h1;
    sck_o   = 1'h0;
    sdi_o   = 1'h0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_i);
  endtask : wait_clk

  // Shifts the low n bits of w, most significant first, and gathers the output bits.
  // The serial clock stands low outside frames, and each phase spans several system clocks.
  task automatic xfer(input logic [31:0] w, input int n, output logic [31:0] rd);
    rd = 32'h0;
    @(posedge clk_i);
    sen_n_o <= 1'h0;
    for (int i = n - 1; i >= 0; i--) begin
      wait_clk(HALF);
      sdi_o <= w[i];
      wait_clk(HALF);
      sck_o <= 1'h1;
      wait_clk(HALF);
      rd = {rd[30:0], sdo_i};
      sck_o <= 1'h0;
    end
    wait_clk(HALF);
    sen_n_o <= 1'h1;
    // The released data line must not keep showing the last bit.
    sdi_o   <= ~sdi_o;
    wait_clk(HALF);
  endtask : xfer
endmodule : ftc_spi_host
`default_nettype wire

// ===== sim/tb_ftc_regs.sv
// Self-checking bench for the filter tuning control register bank.
`timescale 1ns/1ns
`default_nettype none
module tb_ftc_regs;
  import ftc_pkg::*;
  typedef struct packed {
    logic       wen;
    logic [4:0] adr;
    logic [23:0] wd;
    logic [23:0] rb;
  } ftc_row_t;

  logic        clk;
  logic        rst;
  logic        sen_n;
  logic        sck;
  logic        sdi;
  logic        sdo;
  logic        sdo_oe_n;
  logic        rc_cmp;
  logic        st_mode;
  ftc_nv_t     nv_in;
  ftc_analog_t set_o;
  ftc_analog_t exp_set;
  logic        nv_use;
  logic        busy;
  logic [23:0] count;
  logic [15:0] sig;
  logic [23:0] d;
  logic [31:0] w;
  int          fail_count;
  int          num_checks;
  int          meas_steps = 0;
  ftc_row_t    rows [12] = '{
    '{1'h0, FTC_ADR_ENABLES, 24'h000000, 24'h00000C},
    '{1'h0, FTC_ADR_ANALOG,  24'h000000, 24'h000009},
    '{1'h0, FTC_ADR_FINE,    24'h000000, 24'h000000},
    '{1'h0, FTC_ADR_PERIOD,  24'h000000, 24'h000000},
    '{1'h0, FTC_ADR_CORR,    24'h000000, 24'h000000},
    '{1'h1, FTC_ADR_ENABLES, 24'hFFFFFF, 24'h00003F},
    '{1'h1, FTC_ADR_ANALOG,  24'hFFFFFF, 24'h0003FF},
    '{1'h1, FTC_ADR_FINE,    24'hFFFFFB, 24'h00000B},
    '{1'h1, FTC_ADR_PERIOD,  24'hFFFFFF, 24'h007FFF},
    '{1'h1, FTC_ADR_CORR,    24'hFFFFFF, 24'h0001FF},
    '{1'h1, FTC_ADR_SPARE,   24'hFFFFFF, 24'h000000},
    '{1'h1, FTC_ADR_ANALOG,  24'h000236, 24'h000236}
  };

  ftc_regs #(.BIST_CYCLES(16)) u_ftc_regs (
    .CLK_I(clk), .SYS_RST_I(rst), .SPI_SEN_N_I(sen_n), .SPI_SCK_I(sck), .SPI_SDI_I(sdi),
    .SPI_SDO_O(sdo), .SPI_SDO_OE_N_O(sdo_oe_n), .RC_CMP_I(rc_cmp),
    .SELF_TEST_MODE_I(st_mode), .NV_I(nv_in), .SET_O(set_o), .NV_IN_USE_O(nv_use),
    .CAL_BUSY_O(busy), .CAL_COUNT_O(count), .SELF_TEST_SIG_O(sig)
  );

  ftc_spi_host u_ftc_spi_host (
    .clk_i(clk), .sdo_i(sdo), .sen_n_o(sen_n), .sck_o(sck), .sdi_o(sdi)
  );

  always #2 clk = ~clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : test_done

  task automatic wr(input logic [4:0] adr, input logic [23:0] dat);
    u_ftc_spi_host.xfer({dat, adr, FTC_CHIP_ADR}, 32, w);
    repeat (6) @(posedge clk);
  endtask : wr

  // The second frame re-selects the same address so that it changes nothing.
  task automatic rb(input logic [4:0] adr, output logic [23:0] dat);
    wr(FTC_ADR_RDSEL, {19'h00000, adr});
    u_ftc_spi_host.xfer({19'h00000, adr, FTC_ADR_RDSEL, FTC_CHIP_ADR}, 32, w);
    dat = w[31:8];
  endtask : rb

  task automatic wait_busy(input logic lvl);
    int n = 0;
    while (busy !== lvl && n < 100) begin
      @(posedge clk);
      n++;
    end
    if (busy !== lvl) begin
      fail_count++;
      $display("BAD %0t busy wait ran out", $time);
      test_done();
    end
  endtask : wait_busy

  task automatic cal_run(input logic [23:0] en, input logic [14:0] per, input logic [8:0] adj,
                         input logic [23:0] step);
    longint e;
    wr(FTC_ADR_ENABLES, en);
    wr(FTC_ADR_PERIOD, {9'h000, per});
    wr(FTC_ADR_CORR, {15'h0000, adj});
    wr(FTC_ADR_STROBE, 24'hA5A5A5);
    wait_busy(1'h1);
    repeat (5) @(posedge clk);
    rc_cmp <= 1'h1;
    wait_busy(1'h0);
    rc_cmp <= 1'h0;
    repeat (3) @(posedge clk);
    e = (longint'(count) + (longint'($signed(adj)) <<< 10)) >>> 12;
    if (e < 0) e = 0;
    if (e > 11) e = 11;
    // Both runs share one timing, so the first fixes how many periods are counted.
    if (meas_steps == 0) meas_steps = count / step;
    check(count, step * meas_steps);
    check(count == 24'h000000, 1'h0);
    check(set_o.fine_code, e[3:0]);
  endtask : cal_run

  initial begin
    clk     = 1'h0;
    rst     = 1'h1;
    rc_cmp  = 1'h0;
    st_mode = 1'h0;
    nv_in   = '0;
    fail_count = 0;
    num_checks = 0;
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    repeat (3) @(posedge clk);
    exp_set = '{1'h1, 1'h1, 1'h0, 1'h0, 2'h1, 2'h2, 1'h0, 1'h0, 4'h0, 4'h0};
    check(set_o, exp_set);
    check({nv_use, sdo_oe_n, busy}, 3'h2);
    foreach (rows[i]) begin
      if (rows[i].wen) wr(rows[i].adr, rows[i].wd);
      rb(rows[i].adr, d);
      check(d, rows[i].rb);
    end
    exp_set = '{1'h1, 1'h1, 1'h1, 1'h1, 2'h2, 2'h1, 1'h1, 1'h1, 4'h8, 4'hB};
    check(set_o, exp_set);
    // A short frame and a frame for another chip must both leave the settings as they were; the second releases the output line.
    u_ftc_spi_host.xfer({24'h000000, FTC_ADR_ANALOG, FTC_CHIP_ADR}, 31, w);
    u_ftc_spi_host.xfer({24'h000000, FTC_ADR_ANALOG, 3'h2}, 32, w);
    repeat (6) @(posedge clk);
    check(set_o, exp_set);
    check(sdo_oe_n, 1'h1);
    nv_in <= '{1'h1, 4'h3, 4'h2, 1'h1, 1'h0, 2'h3, 2'h0};
    repeat (4) @(posedge clk);
    check(nv_use, 1'h0);
    wr(FTC_ADR_ENABLES, 24'h00001E);
    check(nv_use, 1'h1);
    check({set_o.coarse_code, set_o.opamp_bias, set_o.high_gain_select}, 7'h17);
    nv_in.programmed <= 1'h0;
    repeat (4) @(posedge clk);
    check({nv_use, set_o.coarse_code}, 5'h08);
    cal_run(24'h00000E, 15'h1000, 9'h1D4, 24'h001000);
    cal_run(24'h00002E, 15'h1800, 9'h100, 24'h000C00);
    wr(FTC_ADR_ENABLES, 24'h00000C);
    wr(FTC_ADR_STROBE, 24'h000001);
    repeat (10) @(posedge clk);
    check(busy, 1'h0);
    st_mode <= 1'h1;
    wr(FTC_ADR_STROBE, 24'h000000);
    wait_busy(1'h1);
    wait_busy(1'h0);
    check(sig == 16'h0000, 1'h0);
    st_mode <= 1'h0;
    test_done();
  end
endmodule : tb_ftc_regs
`default_nettype wire
